// ### design/cfgr_config_bank.v
`timescale 1ns/100ps
`include "cfgr_consts.vh"

// ----------------------------------------------------------------------------
// Configuration register bank, special-function and external data spaces.
// ----------------------------------------------------------------------------
module cfgr_config_bank #(
  parameter PROBE_COUNT = 4
) (
  input  wire                   i_ref_clk,
  input  wire                   i_sys_rst,
  // Special-function space access.
  input  wire [7:0]             i_sfr_addr,
  input  wire                   i_sfr_wr,
  input  wire [7:0]             i_sfr_wdata,
  output reg  [7:0]             o_sfr_rdata,
  output wire                   o_sfr_hit,
  // External data space access.
  input  wire [15:0]            i_x_addr,
  input  wire                   i_x_wr,
  input  wire [7:0]             i_x_wdata,
  output reg  [7:0]             o_x_rdata,
  output wire                   o_x_hit,
  // Hardware state shown in read-only fields.
  input  wire                   i_preboot,
  input  wire [6:0]             i_int_flags,
  input  wire [7:0]             i_trim_value,
  // Field outputs.
  output wire [7:0]             o_port0_pins,
  output wire [7:0]             o_port1_pins,
  output wire [7:0]             o_port1_dir,
  output wire [5:0]             o_port2_pins,
  output wire [5:0]             o_port2_dir,
  output wire [7:0]             o_port0_dir,
  output wire [7:0]             o_flash_erase,
  output wire [7:0]             o_ee_data,
  output wire [7:0]             o_ee_ctrl,
  output wire [1:0]             o_flash_ctrl,
  output wire                   o_secure,
  output wire [6:0]             o_flash_page,
  output wire                   o_wd_rst,
  output wire [1:0]             o_irq_enable,
  output wire [8*PROBE_COUNT-1:0] o_probe,
  output wire [7:0]             o_ssi_ctrl,
  output wire [7:0]             o_ssi_first,
  output wire [7:0]             o_ssi_last,
  output wire [7:0]             o_fuse_sel
);

  // --------------------------------------------------------------------------
  // Address decode.
  // --------------------------------------------------------------------------
  function sfr_sel;
    input [7:0] addr;
    input [7:0] target;
    begin
      sfr_sel = (addr == target);
    end
  endfunction

  function x_sel;
    input [15:0] addr;
    input [15:0] target;
    begin
      x_sel = (addr[15:12] == `CFGR_XREGION_NIB) && (addr == target);
    end
  endfunction

  wire [7:0] v_p0;
  wire [7:0] v_p1;
  wire [7:0] v_d1;
  wire [7:0] v_er;
  wire [7:0] v_eed;
  wire [7:0] v_eec;
  wire [7:0] v_p2;
  wire [7:0] v_d2;
  wire [7:0] v_d0;
  wire [7:0] v_fc;
  wire [7:0] v_pg;
  wire [7:0] v_wd;
  wire [7:0] v_sc;
  wire [7:0] v_sf;
  wire [7:0] v_sl;
  wire [7:0] v_fs;
  wire [8*PROBE_COUNT-1:0] v_pr;

  // --------------------------------------------------------------------------
  // Special-function space registers.
  // --------------------------------------------------------------------------
  cfgr_byte_reg #(
    .IMPL_MASK (`CFGR_MASK_ALL)
  ) u_p0 (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr_en   (i_sfr_wr & sfr_sel(i_sfr_addr, `CFGR_SFR_PORT0_PINS)),
    .i_wr_data (i_sfr_wdata),
    .o_value   (v_p0)
  );

  cfgr_byte_reg #(
    .IMPL_MASK (`CFGR_MASK_ALL)
  ) u_p1 (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr_en   (i_sfr_wr & sfr_sel(i_sfr_addr, `CFGR_SFR_PORT1_PINS)),
    .i_wr_data (i_sfr_wdata),
    .o_value   (v_p1)
  );

  cfgr_byte_reg #(
    .IMPL_MASK (`CFGR_MASK_ALL)
  ) u_d1 (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr_en   (i_sfr_wr & sfr_sel(i_sfr_addr, `CFGR_SFR_PORT1_DIR)),
    .i_wr_data (i_sfr_wdata),
    .o_value   (v_d1)
  );

  cfgr_byte_reg #(
    .IMPL_MASK (`CFGR_MASK_ALL)
  ) u_er (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr_en   (i_sfr_wr & sfr_sel(i_sfr_addr, `CFGR_SFR_FLASH_ERASE)),
    .i_wr_data (i_sfr_wdata),
    .o_value   (v_er)
  );

  cfgr_byte_reg #(
    .IMPL_MASK (`CFGR_MASK_ALL)
  ) u_eed (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr_en   (i_sfr_wr & sfr_sel(i_sfr_addr, `CFGR_SFR_EE_DATA)),
    .i_wr_data (i_sfr_wdata),
    .o_value   (v_eed)
  );

  cfgr_byte_reg #(
    .IMPL_MASK (`CFGR_MASK_ALL)
  ) u_eec (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr_en   (i_sfr_wr & sfr_sel(i_sfr_addr, `CFGR_SFR_EE_CTRL)),
    .i_wr_data (i_sfr_wdata),
    .o_value   (v_eec)
  );

  cfgr_byte_reg #(
    .IMPL_MASK (`CFGR_MASK_PORT2)
  ) u_p2 (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr_en   (i_sfr_wr & sfr_sel(i_sfr_addr, `CFGR_SFR_PORT2_PINS)),
    .i_wr_data (i_sfr_wdata),
    .o_value   (v_p2)
  );

  cfgr_byte_reg #(
    .IMPL_MASK (`CFGR_MASK_PORT2)
  ) u_d2 (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr_en   (i_sfr_wr & sfr_sel(i_sfr_addr, `CFGR_SFR_PORT2_DIR)),
    .i_wr_data (i_sfr_wdata),
    .o_value   (v_d2)
  );

  cfgr_byte_reg #(
    .IMPL_MASK (`CFGR_MASK_ALL)
  ) u_d0 (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr_en   (i_sfr_wr & sfr_sel(i_sfr_addr, `CFGR_SFR_PORT0_DIR)),
    .i_wr_data (i_sfr_wdata),
    .o_value   (v_d0)
  );

  cfgr_byte_reg #(
    .IMPL_MASK (`CFGR_MASK_PAGE)
  ) u_pg (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr_en   (i_sfr_wr & sfr_sel(i_sfr_addr, `CFGR_SFR_FLASH_PAGE)),
    .i_wr_data (i_sfr_wdata),
    .o_value   (v_pg)
  );

  cfgr_byte_reg #(
    .IMPL_MASK (`CFGR_MASK_WDOG_IE)
  ) u_wd (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr_en   (i_sfr_wr & sfr_sel(i_sfr_addr, `CFGR_SFR_WDOG_IE)),
    .i_wr_data (i_sfr_wdata),
    .o_value   (v_wd)
  );

  cfgr_sfr_flash_ctrl u_fc (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr_en   (i_sfr_wr & sfr_sel(i_sfr_addr, `CFGR_SFR_FLASH_CTRL)),
    .i_wr_data (i_sfr_wdata),
    .i_preboot (i_preboot),
    .o_value   (v_fc),
    .o_secure  (o_secure)
  );

  // --------------------------------------------------------------------------
  // External data space registers.
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PROBE_COUNT; gi = gi + 1)
    begin : g_probe
      // Each probe byte answers at its own offset from the first probe address.
      localparam integer    PIDX  = gi;
      localparam [15:0]     PADDR = `CFGR_X_PROBE0 + PIDX[15:0];
      cfgr_byte_reg #(
        .IMPL_MASK (`CFGR_MASK_ALL)
      ) u_pr (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_wr_en   (i_x_wr & x_sel(i_x_addr, PADDR)),
        .i_wr_data (i_x_wdata),
        .o_value   (v_pr[8*gi+7:8*gi])
      );
    end
  endgenerate

  cfgr_byte_reg #(
    .IMPL_MASK (`CFGR_MASK_ALL)
  ) u_sc (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr_en   (i_x_wr & x_sel(i_x_addr, `CFGR_X_SSI_CTRL)),
    .i_wr_data (i_x_wdata),
    .o_value   (v_sc)
  );

  cfgr_byte_reg #(
    .IMPL_MASK (`CFGR_MASK_ALL)
  ) u_sf (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr_en   (i_x_wr & x_sel(i_x_addr, `CFGR_X_SSI_FIRST)),
    .i_wr_data (i_x_wdata),
    .o_value   (v_sf)
  );

  cfgr_byte_reg #(
    .IMPL_MASK (`CFGR_MASK_ALL)
  ) u_sl (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr_en   (i_x_wr & x_sel(i_x_addr, `CFGR_X_SSI_LAST)),
    .i_wr_data (i_x_wdata),
    .o_value   (v_sl)
  );

  cfgr_byte_reg #(
    .IMPL_MASK (`CFGR_MASK_ALL)
  ) u_fs (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr_en   (i_x_wr & x_sel(i_x_addr, `CFGR_X_FUSE_SEL)),
    .i_wr_data (i_x_wdata),
    .o_value   (v_fs)
  );

  // --------------------------------------------------------------------------
  // Read multiplexers, same-cycle answer.
  // --------------------------------------------------------------------------
  reg sfr_hit_c;
  reg x_hit_c;
  integer pi;

  // Unmapped addresses read as zero and report no hit.
  always @*
  begin
    o_sfr_rdata = `CFGR_ZERO_BYTE;
    sfr_hit_c   = 1'b1;
    case (i_sfr_addr)
      `CFGR_SFR_PORT0_PINS:  o_sfr_rdata = v_p0;
      `CFGR_SFR_PORT1_PINS:  o_sfr_rdata = v_p1;
      `CFGR_SFR_PORT1_DIR:   o_sfr_rdata = v_d1;
      `CFGR_SFR_FLASH_ERASE: o_sfr_rdata = v_er;
      `CFGR_SFR_EE_DATA:     o_sfr_rdata = v_eed;
      `CFGR_SFR_EE_CTRL:     o_sfr_rdata = v_eec;
      `CFGR_SFR_PORT2_PINS:  o_sfr_rdata = v_p2;
      `CFGR_SFR_PORT2_DIR:   o_sfr_rdata = v_d2;
      `CFGR_SFR_PORT0_DIR:   o_sfr_rdata = v_d0;
      `CFGR_SFR_FLASH_CTRL:  o_sfr_rdata = v_fc;
      `CFGR_SFR_FLASH_PAGE:  o_sfr_rdata = v_pg;
      `CFGR_SFR_WDOG_IE:     o_sfr_rdata = v_wd;
      `CFGR_SFR_INT_FLAGS:   o_sfr_rdata = {1'b0, i_int_flags} & `CFGR_MASK_INT;
      default:               sfr_hit_c   = 1'b0;
    endcase
  end

  // Probe bytes are matched after the case so that they override its default.
  always @*
  begin
    o_x_rdata = `CFGR_ZERO_BYTE;
    x_hit_c   = 1'b0;
    if (i_x_addr[15:12] == `CFGR_XREGION_NIB)
    begin
      x_hit_c = 1'b1;
      case (i_x_addr)
        `CFGR_X_SSI_CTRL:  o_x_rdata = v_sc;
        `CFGR_X_SSI_FIRST: o_x_rdata = v_sf;
        `CFGR_X_SSI_LAST:  o_x_rdata = v_sl;
        `CFGR_X_FUSE_SEL:  o_x_rdata = v_fs;
        `CFGR_X_TRIM:      o_x_rdata = i_trim_value;
        default:           x_hit_c   = 1'b0;
      endcase
      for (pi = 0; pi < PROBE_COUNT; pi = pi + 1)
      begin
        if (i_x_addr == `CFGR_X_PROBE0 + pi[15:0])
        begin
          o_x_rdata = v_pr[8*pi +: 8];
          x_hit_c   = 1'b1;
        end
      end
    end
  end

  assign o_sfr_hit = sfr_hit_c;
  assign o_x_hit   = x_hit_c;

  // --------------------------------------------------------------------------
  // Field outputs to the units and the compute engine.
  // --------------------------------------------------------------------------
  // Every field leaves straight from its register, so the engine never waits.
  assign o_port0_pins  = v_p0;
  assign o_port1_pins  = v_p1;
  assign o_port1_dir   = v_d1;
  assign o_port2_pins  = v_p2[5:0];
  assign o_port2_dir   = v_d2[5:0];
  assign o_port0_dir   = v_d0;
  assign o_flash_erase = v_er;
  assign o_ee_data     = v_eed;
  assign o_ee_ctrl     = v_eec;
  assign o_flash_ctrl  = v_fc[1:0];
  assign o_flash_page  = v_pg[6:0];
  assign o_wd_rst      = v_wd[`CFGR_BIT_WD_RST];
  assign o_irq_enable  = v_wd[1:0];
  assign o_probe       = v_pr;
  assign o_ssi_ctrl    = v_sc;
  assign o_ssi_first   = v_sf;
  assign o_ssi_last    = v_sl;
  assign o_fuse_sel    = v_fs;

endmodule // cfgr_config_bank

// ### design/cfgr_consts.vh
`ifndef CFGR_CONSTS_VH
`define CFGR_CONSTS_VH

// ----------------------------------------------------------------------------
// Special-function space addresses.
// ----------------------------------------------------------------------------
`define CFGR_SFR_PORT0_PINS   8'h80
`define CFGR_SFR_PORT1_PINS   8'h90
`define CFGR_SFR_PORT1_DIR    8'h91
`define CFGR_SFR_FLASH_ERASE  8'h94
`define CFGR_SFR_EE_DATA      8'h9e
`define CFGR_SFR_EE_CTRL      8'h9f
`define CFGR_SFR_PORT2_PINS   8'ha0
`define CFGR_SFR_PORT2_DIR    8'ha1
`define CFGR_SFR_PORT0_DIR    8'ha2
`define CFGR_SFR_FLASH_CTRL   8'hb2
`define CFGR_SFR_FLASH_PAGE   8'hb7
`define CFGR_SFR_WDOG_IE      8'he8
`define CFGR_SFR_INT_FLAGS    8'hf8

// ----------------------------------------------------------------------------
// External data space addresses.
// ----------------------------------------------------------------------------
`define CFGR_XREGION_NIB      4'h2
`define CFGR_X_PROBE0         16'h2060
`define CFGR_X_PROBE3         16'h2063
`define CFGR_X_SSI_CTRL       16'h2070
`define CFGR_X_SSI_FIRST      16'h2071
`define CFGR_X_SSI_LAST       16'h2072
`define CFGR_X_FUSE_SEL       16'h20fd
`define CFGR_X_TRIM           16'h20ff

// ----------------------------------------------------------------------------
// Implemented-bit masks and field positions.
// ----------------------------------------------------------------------------
`define CFGR_MASK_ALL         8'hff
`define CFGR_MASK_PORT2       8'h3f
`define CFGR_MASK_PAGE        8'h7f
`define CFGR_MASK_INT         8'h7f
`define CFGR_MASK_WDOG_IE     8'h83
`define CFGR_MASK_FLASH_RW    8'h03
`define CFGR_BIT_SECURE       6
`define CFGR_BIT_PREBOOT      7
`define CFGR_BIT_WD_RST       7
`define CFGR_RESET_VAL        8'h00
`define CFGR_ZERO_BYTE        8'h00

`endif

// ### design/cfgr_byte_reg.v
`timescale 1ns/100ps
`include "cfgr_consts.vh"

// ----------------------------------------------------------------------------
// Byte register with per-bit implementation mask.
// ----------------------------------------------------------------------------
module cfgr_byte_reg #(
  parameter [7:0] IMPL_MASK = `CFGR_MASK_ALL
) (
  input  wire       i_ref_clk,
  input  wire       i_sys_rst,
  input  wire       i_wr_en,
  input  wire [7:0] i_wr_data,
  output wire [7:0] o_value
);

  reg  [7:0] value_ff;
  wire [7:0] nxt_value;

  assign nxt_value = i_wr_en ? (i_wr_data & IMPL_MASK) : value_ff;

  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      value_ff <= `CFGR_RESET_VAL;
    else
      value_ff <= nxt_value;
  end

  assign o_value = value_ff & IMPL_MASK;

endmodule // cfgr_byte_reg

// ### design/cfgr_sfr_flash_ctrl.v
`timescale 1ns/100ps
`include "cfgr_consts.vh"

// ----------------------------------------------------------------------------
// Flash control byte: boot status read-only, security sticky-set.
// ----------------------------------------------------------------------------
module cfgr_sfr_flash_ctrl (
  input  wire       i_ref_clk,
  input  wire       i_sys_rst,
  input  wire       i_wr_en,
  input  wire [7:0] i_wr_data,
  input  wire       i_preboot,
  output wire [7:0] o_value,
  output wire       o_secure
);

  reg  [1:0] ctrl_ff;
  reg        secure_ff;
  wire [1:0] nxt_ctrl;
  wire       nxt_secure;

  // Security may only be set by software; it clears only on reset.
  assign nxt_ctrl   = i_wr_en ? i_wr_data[1:0] : ctrl_ff;
  assign nxt_secure = secure_ff | (i_wr_en & i_wr_data[`CFGR_BIT_SECURE]);

  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      ctrl_ff   <= 2'h0;
      secure_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff   <= nxt_ctrl;
      secure_ff <= nxt_secure;
    end
  end

  assign o_value  = {i_preboot, secure_ff, 4'h0, ctrl_ff};
  assign o_secure = secure_ff;

endmodule // cfgr_sfr_flash_ctrl

// ### dv/cfgr_config_bank_checker.sv
`timescale 1ns/100ps

// ----------------------------------------
// Port checker for the configuration bank.
// ----------------------------------------
module cfgr_config_bank_checker #(
  parameter PROBE_COUNT = 4
) (
  input wire                     i_ref_clk,
  input wire                     i_sys_rst,
  input wire [7:0]               i_sfr_addr,
  input wire                     i_sfr_wr,
  input wire [7:0]               i_sfr_wdata,
  input wire [7:0]               o_sfr_rdata,
  input wire [15:0]              i_x_addr,
  input wire                     i_x_wr,
  input wire [7:0]               i_x_wdata,
  input wire [7:0]               o_x_rdata,
  input wire                     o_x_hit,
  input wire                     i_preboot,
  input wire [6:0]               i_int_flags,
  input wire [7:0]               i_trim_value,
  input wire [5:0]               o_port2_pins,
  input wire                     o_secure,
  input wire [8*PROBE_COUNT-1:0] o_probe,
  input wire [7:0]               o_ssi_ctrl
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  a_reset_clears : assert property (
    $past(i_sys_rst) |-> o_ssi_ctrl == 8'h00 && o_probe == '0 && !o_secure)
    else $error("fields not cleared by reset");
  a_trim_read_only : assert property (
    i_x_addr == 16'h20ff |-> o_x_rdata == i_trim_value && o_x_hit)
    else $error("trim read does not show hardware value");
  a_flags_read_only : assert property (
    i_sfr_addr == 8'hf8 |-> o_sfr_rdata == {1'b0, i_int_flags})
    else $error("interrupt flags read wrong");
  a_flash_ctrl_view : assert property (
    i_sfr_addr == 8'hb2 |-> o_sfr_rdata[7] == i_preboot &&
    o_sfr_rdata[6] == o_secure && o_sfr_rdata[5:2] == 4'h0)
    else $error("flash control read wrong");
  a_ssi_store : assert property (
    i_x_wr && i_x_addr == 16'h2070 |=> o_ssi_ctrl == $past(i_x_wdata))
    else $error("serial control not loaded");
  a_ssi_readback : assert property (
    i_x_addr == 16'h2070 |-> o_x_rdata == o_ssi_ctrl)
    else $error("serial control readback wrong");
  a_region_decode : assert property (
    i_x_addr[15:12] != 4'h2 |-> !o_x_hit && o_x_rdata == 8'h00)
    else $error("hit outside configuration region");
  a_port2_store : assert property (
    i_sfr_wr && i_sfr_addr == 8'ha0 |=>
    {2'b00, o_port2_pins} == ($past(i_sfr_wdata) & 8'h3f))
    else $error("port 2 pins not loaded");
  a_secure_sticky : assert property (
    o_secure |=> o_secure)
    else $error("secure bit cleared without reset");
  a_probe_hold : assert property (
    !i_x_wr || i_x_addr[15:2] != 14'h0818 |=> $stable(o_probe))
    else $error("probe changed without a store");

  c_ssi_write : cover property (i_x_wr && i_x_addr == 16'h2070);
  c_secure_set : cover property ($rose(o_secure));
  c_trim_read : cover property (i_x_addr == 16'h20ff && i_trim_value != 8'h00);
endmodule // cfgr_config_bank_checker

bind cfgr_config_bank cfgr_config_bank_checker #(
  .PROBE_COUNT(PROBE_COUNT)
) u_cfgr_config_bank_checker (
  .i_ref_clk, .i_sys_rst, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata, .o_sfr_rdata,
  .i_x_addr, .i_x_wr, .i_x_wdata, .o_x_rdata, .o_x_hit, .i_preboot,
  .i_int_flags, .i_trim_value, .o_port2_pins, .o_secure, .o_probe, .o_ssi_ctrl
);

// ### dv/cfgr_cpu_model.sv
`timescale 1ns/100ps

// ----------------------------------------
// Processor side: byte stores and loads.
// ----------------------------------------
module cfgr_cpu_model (
  input  wire         i_ref_clk,
  input  wire  [7:0]  i_sfr_rdata,
  input  wire  [7:0]  i_x_rdata,
  output logic [7:0]  o_sfr_addr,
  output logic        o_sfr_wr,
  output logic [7:0]  o_sfr_wdata,
  output logic [15:0] o_x_addr,
  output logic        o_x_wr,
  output logic [7:0]  o_x_wdata
);
  logic [7:0] boot_img [0:3];

  initial
  begin
    o_sfr_addr = 8'h00;
    o_sfr_wr = 1'b0;
    o_sfr_wdata = 8'h00;
    o_x_addr = 16'h0000;
    o_x_wr = 1'b0;
    o_x_wdata = 8'h00;
    boot_img = '{8'h11, 8'h22, 8'h44, 8'h88};
  end

  // After each access both buses invert their address and data, so an unused bus toggles to the inverse of its earlier value.
  task automatic acc(input logic x, input logic w, input logic [15:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge i_ref_clk);
    if (x)
    begin
      o_x_addr <= a;
      o_x_wr <= w;
      o_x_wdata <= d;
    end
    else
    begin
      o_sfr_addr <= a[7:0];
      o_sfr_wr <= w;
      o_sfr_wdata <= d;
    end
    @(posedge i_ref_clk);
    q = x ? i_x_rdata : i_sfr_rdata;
    o_x_wr <= 1'b0;
    o_sfr_wr <= 1'b0;
    o_x_addr <= ~o_x_addr;
    o_x_wdata <= ~o_x_wdata;
    o_sfr_addr <= ~o_sfr_addr;
    o_sfr_wdata <= ~o_sfr_wdata;
  endtask

  task automatic set_bits(input logic [7:0] a, input logic [7:0] m);
    logic [7:0] q;
    logic [7:0] junk;
    acc(1'b0, 1'b0, {8'h00, a}, 8'h00, q);
    acc(1'b0, 1'b1, {8'h00, a}, q | m, junk);
  endtask

  task automatic boot_copy;
    logic [7:0] junk;
    for (int i = 0; i < 4; i++)
      acc(1'b1, 1'b1, 16'h2060 + 16'(i), boot_img[i], junk);
  endtask
endmodule // cfgr_cpu_model

// ### dv/cfgr_config_bank_tb.sv
`timescale 1ns/100ps

module cfgr_config_bank_tb;
  logic        i_ref_clk;
  logic        i_sys_rst;
  logic        i_preboot;
  logic [6:0]  i_int_flags;
  logic [7:0]  i_trim_value;
  wire  [7:0]  sfr_addr, sfr_wdata, sfr_rdata, x_wdata, x_rdata, ssi_ctrl;
  wire  [15:0] x_addr;
  wire  [31:0] probe;
  wire  [5:0]  port2_pins;
  wire         sfr_wr, x_wr, secure;
  wire  [7:0]  p0_pins, p1_pins, p1_dir, p0_dir, erase, ee_data, ee_ctrl;
  wire  [7:0]  ssi_first, ssi_last, fuse_sel;
  wire  [6:0]  flash_page;
  wire  [5:0]  port2_dir;
  wire  [1:0]  flash_ctrl, irq_enable;
  wire         sfr_hit, x_hit, wd_rst;
  int          err_count;
  int          compares;
  logic [7:0]  sfr_a [0:10] = '{8'h80, 8'h90, 8'h91, 8'h94, 8'h9e, 8'h9f,
                               8'ha0, 8'ha1, 8'ha2, 8'hb7, 8'he8};
  logic [7:0]  sfr_m [0:10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
                               8'h3f, 8'h3f, 8'hff, 8'h7f, 8'h83};
  logic [15:0] x_a [0:7] = '{16'h2060, 16'h2061, 16'h2062, 16'h2063,
                             16'h2070, 16'h2071, 16'h2072, 16'h20fd};

  cfgr_config_bank #(.PROBE_COUNT(4)) u_cfgr_config_bank (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_sfr_addr(sfr_addr),
    .i_sfr_wr(sfr_wr), .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(sfr_rdata),
    .o_sfr_hit(sfr_hit), .i_x_addr(x_addr), .i_x_wr(x_wr), .i_x_wdata(x_wdata),
    .o_x_rdata(x_rdata), .o_x_hit(x_hit), .i_preboot(i_preboot),
    .i_int_flags(i_int_flags), .i_trim_value(i_trim_value), .o_port0_pins(p0_pins),
    .o_port1_pins(p1_pins), .o_port1_dir(p1_dir), .o_port2_pins(port2_pins),
    .o_port2_dir(port2_dir), .o_port0_dir(p0_dir), .o_flash_erase(erase),
    .o_ee_data(ee_data), .o_ee_ctrl(ee_ctrl), .o_flash_ctrl(flash_ctrl),
    .o_secure(secure), .o_flash_page(flash_page), .o_wd_rst(wd_rst),
    .o_irq_enable(irq_enable), .o_probe(probe), .o_ssi_ctrl(ssi_ctrl),
    .o_ssi_first(ssi_first), .o_ssi_last(ssi_last), .o_fuse_sel(fuse_sel)
  );

  cfgr_cpu_model u_cfgr_cpu_model (
    .i_ref_clk(i_ref_clk), .i_sfr_rdata(sfr_rdata), .i_x_rdata(x_rdata),
    .o_sfr_addr(sfr_addr), .o_sfr_wr(sfr_wr), .o_sfr_wdata(sfr_wdata),
    .o_x_addr(x_addr), .o_x_wr(x_wr), .o_x_wdata(x_wdata)
  );

  // ----------------------------------------
  // Shared tasks.
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic x, input logic [15:0] a, input logic [7:0] d);
    logic [7:0] junk;
    u_cfgr_cpu_model.acc(x, 1'b1, a, d, junk);
  endtask

  task automatic chk_rd(input logic x, input logic [15:0] a, input logic [7:0] e);
    logic [7:0] q;
    u_cfgr_cpu_model.acc(x, 1'b0, a, 8'h00, q);
    check(q, e);
  endtask

  task automatic do_reset;
    @(posedge i_ref_clk);
    i_sys_rst <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
  endtask

  task automatic close_out;
    $display("compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic t_reset_vals;
    for (int i = 0; i < 11; i++)
      chk_rd(1'b0, {8'h00, sfr_a[i]}, 8'h00);
    for (int i = 0; i < 8; i++)
      chk_rd(1'b1, x_a[i], 8'h00);
    chk_rd(1'b0, 16'h00b2, {i_preboot, 7'h00});
    check(probe, 32'h0000_0000);
    $display("test reset values done");
  endtask

  task automatic t_sfr_rw;
    logic [7:0] pat;
    for (int p = 0; p < 2; p++)
    begin
      pat = p ? 8'h5a : 8'hff;
      for (int i = 0; i < 11; i++)
      begin
        wr(1'b0, {8'h00, sfr_a[i]}, pat);
        chk_rd(1'b0, {8'h00, sfr_a[i]}, pat & sfr_m[i]);
      end
    end
    check(sfr_hit, 1'b1);
    check(port2_pins, 6'h1a);
    check({p0_pins, p1_pins, p1_dir, p0_dir}, 32'h5a5a_5a5a);
    check({erase, ee_data, ee_ctrl}, 32'h005a_5a5a);
    check({port2_dir, flash_page, wd_rst, irq_enable}, {6'h1a, 7'h5a, 1'b0, 2'h2});
    wr(1'b0, 16'h0081, 8'hff);
    chk_rd(1'b0, 16'h0081, 8'h00);
    check(sfr_hit, 1'b0);
    $display("test special-function space done");
  endtask

  task automatic t_x_rw;
    u_cfgr_cpu_model.boot_copy();
    @(negedge i_ref_clk);
    check(probe, 32'h8844_2211);
    for (int i = 0; i < 8; i++)
    begin
      wr(1'b1, x_a[i], 8'ha5 ^ 8'(i));
      chk_rd(1'b1, x_a[i], 8'ha5 ^ 8'(i));
    end
    wr(1'b1, 16'h3070, 8'h3c);
    chk_rd(1'b1, 16'h2070, 8'ha1);
    check(x_hit, 1'b1);
    chk_rd(1'b1, 16'h3070, 8'h00);
    check(x_hit, 1'b0);
    chk_rd(1'b1, 16'h2073, 8'h00);
    check(ssi_ctrl, 8'ha1);
    check({ssi_first, ssi_last, fuse_sel}, 32'h00a0_a3a2);
    $display("test external space done");
  endtask

  task automatic t_read_only;
    i_trim_value <= 8'h3c;
    i_int_flags <= 7'h55;
    i_preboot <= 1'b1;
    wr(1'b1, 16'h20ff, 8'h00);
    chk_rd(1'b1, 16'h20ff, 8'h3c);
    wr(1'b0, 16'h00f8, 8'hff);
    chk_rd(1'b0, 16'h00f8, 8'h55);
    u_cfgr_cpu_model.set_bits(8'hb2, 8'h41);
    chk_rd(1'b0, 16'h00b2, 8'hc1);
    check({secure, flash_ctrl}, 3'h5);
    wr(1'b0, 16'h00b2, 8'h00);
    chk_rd(1'b0, 16'h00b2, 8'hc0);
    check({secure, flash_ctrl}, 3'h4);
    do_reset();
    chk_rd(1'b0, 16'h00b2, 8'h80);
    check(ssi_ctrl, 8'h00);
    check(secure, 1'b0);
    $display("test read-only fields done");
  endtask

  initial
  begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  initial
  begin
    #100us;
    err_count++;
    $display("ERROR %0t: watchdog expired", $time);
    close_out();
  end

  initial
  begin
    i_sys_rst = 1'b1;
    i_preboot = 1'b0;
    i_int_flags = 7'h00;
    i_trim_value = 8'h00;
    repeat (4) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    t_reset_vals();
    t_sfr_rw();
    t_x_rw();
    t_read_only();
    close_out();
  end
endmodule // cfgr_config_bank_tb
